// ### hdl/ica_consts.svh
`ifndef ICA_CONSTS_SVH
`define ICA_CONSTS_SVH

// Base address pairs chosen by the strap
`define ICA_BASE_STRAP_HI 16'h002e
`define ICA_BASE_STRAP_LO 16'h004e
// Register offsets from the base
`define ICA_OFS_POINTER 1'b0
`define ICA_OFS_WINDOW 1'b1
// Reset value of the pointer
`define ICA_POINTER_RST 8'h00
// Reset values of the unbanked and banked state
`define ICA_SELECTOR_RST 8'h00
`define ICA_GLOBAL_RST 8'h00
`define ICA_ACTIVATE_RST 9'h000
// Configuration indices
`define ICA_IDX_SELECTOR 8'h07
`define ICA_IDX_GLOBAL_LO 8'h20
`define ICA_IDX_GLOBAL_HI 8'h2f
`define ICA_IDX_BANK_FIRST 8'h30
`define ICA_IDX_ACTIVATE 8'h30
`define ICA_IDX_DMA0 8'h74
`define ICA_IDX_DMA1 8'h75
// Read values of missing registers
`define ICA_UNIMPL_RD 8'h00
`define ICA_NO_DMA_RD 8'h04
// Bank geometry
`define ICA_NUM_BANKS 9
`define ICA_ACTIVATE_BIT 0

`endif

// ### hdl/ica_pkg.sv
package ica_pkg;
    // One host I/O byte access
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } ica_req_s;
    // Answer to a host read
    typedef struct packed {
        logic       hit;
        logic [7:0] rdata;
    } ica_rsp_s;
endpackage

// ### hdl/ica_top.sv
// How it works
// [R1] The strap is sampled in reset: high gives pair 2Eh/2Fh, low gives 4Eh/4Fh.
// [R2] Exactly two consecutive I/O bytes are decoded: pointer then window.
// [R3] The pointer at base plus zero is an 8-bit read/write register selecting the target.
// [R4] The pointer reads back its last written value, 00h after reset.
// [R5] Every access at base plus one goes to the register the pointer selects.
// [R6] The selector and global registers are reached whatever bank is selected.
// [R7] Only index 30h reaches the bank named by the selector; other indices from 30h up are missing.
// [R8] Nine separate banks of per-device registers are kept.
// [R9] The host leaves unassigned selector values unprogrammed.
// [R10] Writes to missing registers are dropped with no state change.
// [R11] Missing registers read 00h, except 74h and 75h which read 04h.
// [R12] Accesses are served from the first cycle after reset.
// [R13] Per-device fields drive dedicated control outputs.
// [R14] The selector lives at index 07h and picks the active bank.
// [R15] Bit 0 of index 30h in each bank enables its device; bits 7 to 1 are reserved.
// [R16] The strap value is held from reset release until the next reset.
`timescale 1ns/10ps
`include "ica_consts.svh"

module ica_top (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic base_address_strap,
    input wire ica_pkg::ica_req_s req,
    output ica_pkg::ica_rsp_s rsp,
    output logic [7:0] logical_device_selector,
    output logic [`ICA_NUM_BANKS-1:0] device_enable
);

    // Strap synchroniser stages
    logic strap_s1_q, strap_s2_q, strap_s3_q;
    logic strap_s1_d, strap_s2_d, strap_s3_d;
    // Base choice, caught only while in reset
    logic base_hi_q, base_hi_d;
    // Host-visible pointer and unbanked registers
    logic [7:0] pointer_q, pointer_d;
    logic [7:0] selector_q, selector_d;
    logic [7:0] global_q [16];
    logic [7:0] global_d [16];
    // One activate bit per logical device bank
    logic [`ICA_NUM_BANKS-1:0] activate_q, activate_d;
    // Registered answer, so read data comes from a flop
    ica_pkg::ica_rsp_s rsp_q, rsp_d;
    // Pair decode and window strobes
    logic [15:0] base;
    logic hit_ptr, hit_win;
    logic win_wr, win_rd;

    // Index of 20h..2Fh global register
    function automatic logic is_global(input logic [7:0] idx);
        return idx >= `ICA_IDX_GLOBAL_LO && idx <= `ICA_IDX_GLOBAL_HI;
    endfunction

    // Selector names an existing bank
    function automatic logic bank_ok(input logic [7:0] sel);
        return sel < 8'(`ICA_NUM_BANKS);
    endfunction

    // Index of the unbanked bank selector
    function automatic logic is_selector(input logic [7:0] idx);
        return idx == `ICA_IDX_SELECTOR;
    endfunction

    // Activate index, present only when the selector names a real bank
    function automatic logic is_activate(input logic [7:0] idx, input logic [7:0] sel);
        return idx == `ICA_IDX_ACTIVATE && bank_ok(sel);
    endfunction

    // DMA indices, which read back as no channel assigned
    function automatic logic is_dma(input logic [7:0] idx);
        return idx == `ICA_IDX_DMA0 || idx == `ICA_IDX_DMA1;
    endfunction

    // Address decode of the pair
    always_comb
    begin
        base = base_hi_q ? `ICA_BASE_STRAP_HI : `ICA_BASE_STRAP_LO; // R1
        hit_ptr = req.addr == base; // R2
        hit_win = req.addr == (base | 16'(`ICA_OFS_WINDOW)); // R2
        // Strobes qualify the window hit once for every register group
        win_wr = req.wr && hit_win;
        win_rd = req.rd && hit_win; // R5
    end

    // Strap sampling; tracks the pin only while in reset
    always_comb
    begin
        strap_s1_d = base_address_strap;
        strap_s2_d = strap_s1_q;
        strap_s3_d = strap_s2_q;
        base_hi_d = base_hi_q;
        // Accept a level only when two stages agree, so a glitch cannot land
        if (srst && strap_s2_q == strap_s3_q)
        begin
            base_hi_d = strap_s3_q; // R1
        end
        // Outside reset base_hi_q holds, keeping the pair fixed
    end

    // Register file next state
    always_comb
    begin
        pointer_d = pointer_q;
        selector_d = selector_q;
        activate_d = activate_q;
        rsp_d = '0;
        // Pointer write takes the byte as it is
        if (req.wr && hit_ptr)
        begin
            pointer_d = req.wdata; // R3
        end
        // Only existing targets take a write; a missing index falls through untouched
        if (win_wr) // R10
        begin
            if (is_selector(pointer_q))
            begin
                selector_d = req.wdata; // R14
            end
            else if (is_activate(pointer_q, selector_q))
            begin
                activate_d[selector_q[3:0]] = req.wdata[`ICA_ACTIVATE_BIT]; // R7 R15
            end
            // Global indices are stored by their own slots below
        end
        // Pointer read returns the last byte written
        if (req.rd && hit_ptr)
        begin
            rsp_d.hit = 1'b1;
            rsp_d.rdata = pointer_q; // R4
        end
        // Window reads: missing indices read zero, DMA ones the no-channel code
        if (win_rd)
        begin
            rsp_d.hit = 1'b1; // R5
            if (is_selector(pointer_q))
            begin
                rsp_d.rdata = selector_q; // R6
            end
            else if (is_global(pointer_q))
            begin
                rsp_d.rdata = global_q[pointer_q[3:0]]; // R6
            end
            else if (is_activate(pointer_q, selector_q))
            begin
                rsp_d.rdata = {7'h00, activate_q[selector_q[3:0]]}; // R7 R15
            end
            else if (is_dma(pointer_q))
            begin
                rsp_d.rdata = `ICA_NO_DMA_RD; // R11
            end
            else
            begin
                rsp_d.rdata = `ICA_UNIMPL_RD; // R11
            end
        end
    end

    // Strap stages keep running during reset so the level is caught there
    always_ff @(posedge clk)
    begin
        if (ce)
        begin
            strap_s1_q <= strap_s1_d;
            strap_s2_q <= strap_s2_d;
            strap_s3_q <= strap_s3_d;
            base_hi_q <= base_hi_d; // R16
        end
    end

    // Register file state; live from the first edge after reset
    // Reset wins over a low enable so a frozen block can still be cleared
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            pointer_q <= `ICA_POINTER_RST; // R4
            selector_q <= `ICA_SELECTOR_RST;
            activate_q <= `ICA_ACTIVATE_RST;
            rsp_q <= '0;
        end
        else if (ce)
        begin
            pointer_q <= pointer_d; // R12
            selector_q <= selector_d;
            activate_q <= activate_d; // R8
            rsp_q <= rsp_d;
        end
    end

    // Global registers, one slot per index; the selector never reaches them
    for (genvar g = 0; g < 16; g++)
    begin : g_global
        // A window write aimed at this slot replaces it
        always_comb
        begin
            global_d[g] = global_q[g];
            if (win_wr && is_global(pointer_q) && pointer_q[3:0] == 4'(g))
            begin
                global_d[g] = req.wdata; // R6
            end
        end

        // Slot flop; a low enable holds it like the rest of the file
        always_ff @(posedge clk)
        begin
            if (srst)
            begin
                global_q[g] <= `ICA_GLOBAL_RST;
            end
            else if (ce)
            begin
                global_q[g] <= global_d[g];
            end
        end
    end

    // Outputs come straight from flops so the far side sees no decode glitches
    assign rsp = rsp_q;
    assign logical_device_selector = selector_q; // R14
    assign device_enable = activate_q; // R13

endmodule // ica_top

// ### sim/ica_top_properties.sv
`timescale 1ns/10ps
module ica_top_properties (
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic base_address_strap,
    input wire ica_pkg::ica_req_s req,
    input wire ica_pkg::ica_rsp_s rsp,
    input wire logic [7:0] logical_device_selector,
    input wire logic [8:0] device_enable
);
    logic hi_q;
    logic [7:0] ptr_q;
    logic at_b;
    logic at_w;
    // Own copy of strap and pointer, so decode is judged independently
    always_ff @(posedge clk)
    begin
        if (srst) hi_q <= base_address_strap;
        ptr_q <= srst ? 8'h00 : (at_b && req.wr ? req.wdata : ptr_q);
    end
    assign at_b = ce && req.addr == (hi_q ? 16'h002e : 16'h004e);
    assign at_w = ce && req.addr == (hi_q ? 16'h002f : 16'h004f);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    sequence s_win_wr; at_w && req.wr; endsequence
    sequence s_win_rd; at_w && req.rd; endsequence
    property p_hit; (at_b || at_w) && req.rd |=> rsp.hit; endproperty
    a_hit: assert property (p_hit) else $error("no hit");
    property p_miss; ce && !((at_b || at_w) && req.rd) |=> !rsp.hit; endproperty
    a_miss: assert property (p_miss) else $error("stray hit");
    property p_zero; !rsp.hit |-> rsp.rdata == 8'h00; endproperty
    a_zero: assert property (p_zero) else $error("rdata idle");
    property p_ptr; at_b && req.rd |=> rsp.rdata == $past(ptr_q); endproperty
    a_ptr: assert property (p_ptr) else $error("pointer read");
    property p_sel; s_win_wr ##0 ptr_q == 8'h07
        |=> logical_device_selector == $past(req.wdata); endproperty
    a_sel: assert property (p_sel) else $error("selector");
    property p_hold; !(at_w && req.wr)
        |=> $stable(logical_device_selector) && $stable(device_enable); endproperty
    a_hold: assert property (p_hold) else $error("state moved");
    property p_dma; s_win_rd ##0 ptr_q[7:1] == 7'h3a |=> rsp.rdata == 8'h04; endproperty
    a_dma: assert property (p_dma) else $error("dma read");
    property p_en; s_win_wr ##0 ptr_q == 8'h30 && logical_device_selector < 8'h09
        |=> device_enable[$past(logical_device_selector[3:0])] == $past(req.wdata[0]);
    endproperty
    a_en: assert property (p_en) else $error("enable");
endmodule // ica_top_properties
bind ica_top ica_top_properties u_props (.clk(clk), .srst(srst), .ce(ce),
    .base_address_strap(base_address_strap), .req(req), .rsp(rsp),
    .logical_device_selector(logical_device_selector), .device_enable(device_enable));

// ### sim/ica_host_model.sv
`timescale 1ns/10ps
module ica_host_model (
    input wire logic clk,
    input wire ica_pkg::ica_rsp_s rsp,
    output ica_pkg::ica_req_s req
);
    // One byte cycle; lines toggle when released so stale values never match
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d,
        output logic [8:0] got);
        @(posedge clk);
        #1 req = '{rd: !w, wr: w, addr: a, wdata: d};
        @(posedge clk);
        #1 req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
        got = {rsp.hit, rsp.rdata};
    endtask
    initial req = '0;
endmodule // ica_host_model

// ### sim/indexed_config_access_tb.sv
`timescale 1ns/10ps
module indexed_config_access_tb;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic ce = 1'b1;
    logic strap = 1'b1;
    logic [15:0] base = 16'h002e;
    ica_pkg::ica_req_s req;
    ica_pkg::ica_rsp_s rsp;
    logic [7:0] sel;
    logic [8:0] en;
    logic [8:0] got;
    int fail_count = 0;
    int checks_done = 0;
    always #2.5 clk = ~clk;
    ica_top u_dut (.clk(clk), .srst(srst), .ce(ce), .base_address_strap(strap),
        .req(req), .rsp(rsp), .logical_device_selector(sel), .device_enable(en));
    ica_host_model u_host (.clk(clk), .rsp(rsp), .req(req));
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic rst(input logic s);
        @(posedge clk);
        #1 srst = 1'b1;
        strap = s;
        repeat (6) @(posedge clk);
        #1 srst = 1'b0;
    endtask
    task automatic put(input logic [7:0] i, input logic [7:0] d);
        u_host.io(1'b1, base, i, got);
        u_host.io(1'b1, base + 16'h0001, d, got);
    endtask
    task automatic get(input logic [7:0] i, input logic [8:0] exp);
        u_host.io(1'b1, base, i, got);
        u_host.io(1'b0, base + 16'h0001, 8'h00, got);
        chk(got, exp);
    endtask
    // Only assigned selector values are used by the host
    task automatic t_banks;
        u_host.io(1'b0, base, 8'h00, got);
        chk(got, 9'h100);
        put(8'h07, 8'h03);
        put(8'h30, 8'h01);
        put(8'h07, 8'h08);
        put(8'h30, 8'hff);
        chk(en, 9'h108);
        get(8'h30, 9'h101);
        put(8'h22, 8'h5a);
        put(8'h07, 8'h03);
        get(8'h30, 9'h101);
        get(8'h22, 9'h15a);
        get(8'h07, 9'h103);
        put(8'h30, 8'h00);
        chk(en, 9'h100);
        put(8'h30, 8'h01);
        chk(en, 9'h108);
    endtask
    task automatic t_missing;
        put(8'h40, 8'h77);
        get(8'h40, 9'h100);
        get(8'h74, 9'h104);
        get(8'h75, 9'h104);
        u_host.io(1'b0, base, 8'h00, got);
        chk(got, 9'h175);
        chk(en, 9'h108);
    endtask
    // Low enable freezes every register: a write presented under it is lost
    task automatic t_enable;
        @(posedge clk);
        #1 ce = 1'b0;
        u_host.io(1'b1, base, 8'h5c, got);
        ce = 1'b1;
        u_host.io(1'b0, base, 8'h00, got);
        chk(got, 9'h175);
    endtask
    // Strap moved after release must not move the pair
    task automatic t_strap;
        rst(1'b0);
        base = 16'h004e;
        strap = 1'b1;
        chk({1'b0, sel}, 9'h000);
        chk(en, 9'h000);
        put(8'h07, 8'h05);
        get(8'h07, 9'h105);
        u_host.io(1'b0, 16'h002f, 8'h00, got);
        chk(got, 9'h000);
    endtask
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial
    begin
        rst(1'b1);
        t_banks;
        t_missing;
        t_enable;
        t_strap;
        print_verdict;
    end
endmodule // indexed_config_access_tb
